//--- rtl/cmp_pkg.sv
// constants and types for the comparator control block
//
// Overview of operation
// - comparator runs only while its enable bit is set; otherwise lowest power.
// - raw result high when positive input exceeds negative input.
// - result readable from control status bit and from shared mirror register.
// - invert bit set inverts the result; clear passes it through.
// - internal output registered each instruction cycle; pin outputs not latched.
// - sync bit enables resynchronisation of output to timer-1 clock.
// - with sync, output captured on each timer-1 source clock falling edge.
// - comparator output available as timer-1 gate source.
// - enabled rising or falling output edge sets the interrupt flag.
// - only software clears the flag; an edge during clearing wins.
// - edges from invert or enable toggles still raise the flag.
// - three-bit positive channel field selects pin, DAC, reference or ground.
// - three-bit negative channel field selects pin, reference or analog ground.
// - with enable clear, every input selection is disconnected.
// - hysteresis bit adds separation voltage to inputs while set.
// - active output with shutdown source enable suspends waveform generator.
// - keeps working in sleep; sync path stops if timer-1 runs from system clock.
// - comparator interrupt wakes the device if its irq enable is set.
// - mirror register bit1 is comparator 2, bit0 comparator 1, rest zero.
package cmp_pkg;
  localparam int unsigned CMP_SYS_CLK_HZ   = 100_000_000;
  localparam int unsigned CMP_INSTR_DIV    = 4;        // instruction cycle = four system clocks
  localparam int unsigned CMP_NUM          = 2;
  localparam int unsigned CMP_CH_W         = 3;
  // channel codes of the positive selector
  localparam logic [2:0]  CMP_PCH_PIN      = 3'h0;
  localparam logic [2:0]  CMP_PCH_DAC      = 3'h5;
  localparam logic [2:0]  CMP_PCH_FVR      = 3'h6;
  localparam logic [2:0]  CMP_PCH_GND      = 3'h7;
  // channel codes of the negative selector
  localparam logic [2:0]  CMP_NCH_PIN      = 3'h0;
  localparam logic [2:0]  CMP_NCH_FVR      = 3'h6;
  localparam logic [2:0]  CMP_NCH_GND      = 3'h7;
  // one-hot analog switch enables
  localparam int unsigned CMP_PSW_W        = 4;
  localparam int unsigned CMP_NSW_W        = 3;
  localparam logic [3:0]  CMP_PSW_NONE     = 4'h0;
  localparam logic [3:0]  CMP_PSW_PIN      = 4'h1;
  localparam logic [3:0]  CMP_PSW_DAC      = 4'h2;
  localparam logic [3:0]  CMP_PSW_FVR      = 4'h4;
  localparam logic [3:0]  CMP_PSW_GND      = 4'h8;
  localparam logic [2:0]  CMP_NSW_NONE     = 3'h0;
  localparam logic [2:0]  CMP_NSW_PIN      = 3'h1;
  localparam logic [2:0]  CMP_NSW_FVR      = 3'h2;
  localparam logic [2:0]  CMP_NSW_GND      = 3'h4;
  localparam int unsigned CMP_MIRROR_W     = 8;
  localparam logic [7:0]  CMP_MIRROR_RST   = 8'h00;
  typedef enum logic [1:0] {CMP_T1_SYS, CMP_T1_INSTR, CMP_T1_EXT} cmp_t1src_e;
endpackage : cmp_pkg

//--- rtl/cmp_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module cmp_sync3 (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic s1_r, s2_r, s3_r, out_r, out_nxt;

  // change counts once second and third stage agree
  always_comb begin
    out_nxt = out_r;
    if (s2_r == s3_r) begin
      out_nxt = s3_r;
    end
  end

  // stage registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      out_r <= 1'b0;
    end else begin
      s1_r  <= async_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;
endmodule : cmp_sync3

//--- rtl/cmp_channel.sv
// one comparator channel: polarity, latch, sync, edges, flag
`timescale 1ns/100ps
module cmp_channel
  import cmp_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  input  wire logic                instr_tick,
  input  wire logic                t1_fall_tick,
  input  wire logic                raw_sync,
  input  wire logic                enable,
  input  wire logic                invert,
  input  wire logic                sync_en,
  input  wire logic                rise_en,
  input  wire logic                fall_en,
  input  wire logic                flag_clear,
  output logic                     result,
  output logic                     flag
);
  logic lat_r, lat_nxt, syn_r, syn_nxt, prev_r, prev_nxt, flag_r, flag_nxt;
  logic pol, cur, rise, fall;

  // next values: latch, sync capture, edge detect, sticky flag
  always_comb begin
    pol      = enable & (raw_sync ^ invert);
    lat_nxt  = instr_tick ? pol : lat_r;
    syn_nxt  = t1_fall_tick ? lat_r : syn_r;
    cur      = sync_en ? syn_r : lat_r;
    rise     = cur & ~prev_r;
    fall     = ~cur & prev_r;
    prev_nxt = cur;
    flag_nxt = flag_r;
    if (flag_clear) begin
      flag_nxt = 1'b0;
    end
    if ((rise & rise_en) | (fall & fall_en)) begin
      flag_nxt = 1'b1;
    end
  end

  // state registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lat_r  <= 1'b0;
      syn_r  <= 1'b0;
      prev_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      lat_r  <= lat_nxt;
      syn_r  <= syn_nxt;
      prev_r <= prev_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign result = cur;
  assign flag   = flag_r;
endmodule : cmp_channel

//--- rtl/cmp_ctrl.sv
// top of comparator digital control, two channels
`timescale 1ns/100ps
module cmp_ctrl
  import cmp_pkg::*;
#(
  parameter int unsigned NUM = CMP_NUM
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire logic [NUM-1:0]       raw_result,
  input  wire logic                 t1_src_clk,
  input  wire cmp_pkg::cmp_t1src_e  t1_src_sel,
  input  wire logic                 sleep_mode,
  input  wire logic [NUM-1:0]       comparator_enable_bit,
  input  wire logic [NUM-1:0]       output_invert_bit,
  input  wire logic [NUM-1:0]       hysteresis_enable_bit,
  input  wire logic [NUM-1:0]       timer_sync_enable_bit,
  input  wire logic [NUM-1:0]       rising_edge_irq_enable,
  input  wire logic [NUM-1:0]       falling_edge_irq_enable,
  input  wire logic [NUM*3-1:0]     positive_channel_select,
  input  wire logic [NUM*3-1:0]     negative_channel_select,
  input  wire logic [NUM-1:0]       comparator_irq_enable,
  input  wire logic [NUM-1:0]       irq_flag_clear,
  input  wire logic [NUM-1:0]       shutdown_source_enable,
  output logic [NUM-1:0]            comparator_result_bit,
  output logic [7:0]                shared_output_mirror_register,
  output logic [NUM-1:0]            comparator_irq_flag,
  output logic [NUM-1:0]            timer1_gate_source,
  output logic [NUM-1:0]            pin_route_out,
  output logic                      waveform_shutdown,
  output logic                      wake_request,
  output logic [NUM-1:0]            hysteresis_on,
  output logic [NUM*4-1:0]          positive_switch,
  output logic [NUM*3-1:0]          negative_switch
);
  localparam logic [1:0] DIV_LAST = 2'(CMP_INSTR_DIV - 1);

  logic [1:0]      div_r, div_nxt;
  logic            instr_tick;
  logic            t1_sync, t1_prev_r, t1_fall_tick;
  logic [NUM-1:0]  raw_sync, res, flg;
  logic [NUM-1:0]  res_r, flg_r, gate_r, pin_r, hys_r;
  logic [NUM-1:0]  pin_nxt;
  logic [7:0]      mir_r, mir_nxt;
  logic            shut_r, wake_r, shut_nxt, wake_nxt;
  logic [NUM*4-1:0] psw_r, psw_nxt;
  logic [NUM*3-1:0] nsw_r, nsw_nxt;

  // instruction cycle divider
  always_comb begin
    div_nxt    = (div_r == DIV_LAST) ? 2'h0 : div_r + 2'h1;
    instr_tick = (div_r == DIV_LAST);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // timer-1 source clock sampled as a pin
  cmp_sync3 u_t1 (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .async_in (t1_src_clk),
    .sync_out (t1_sync)
  );

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      t1_prev_r <= 1'b0;
    end else begin
      t1_prev_r <= t1_sync;
    end
  end

  // falling edge; timer stops in sleep on internal sources
  assign t1_fall_tick = t1_prev_r & ~t1_sync & ~(sleep_mode & (t1_src_sel != CMP_T1_EXT));

  // per channel path
  genvar g;
  generate
    for (g = 0; g < NUM; g++) begin : g_ch
      cmp_sync3 u_raw (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .async_in (raw_result[g]),
        .sync_out (raw_sync[g])
      );
      cmp_channel u_ch (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .instr_tick   (instr_tick),
        .t1_fall_tick (t1_fall_tick),
        .raw_sync     (raw_sync[g]),
        .enable       (comparator_enable_bit[g]),
        .invert       (output_invert_bit[g]),
        .sync_en      (timer_sync_enable_bit[g]),
        .rise_en      (rising_edge_irq_enable[g]),
        .fall_en      (falling_edge_irq_enable[g]),
        .flag_clear   (irq_flag_clear[g]),
        .result       (res[g]),
        .flag         (flg[g])
      );
      // input switch decode, all open while disabled
      always_comb begin
        psw_nxt[g*4 +: 4] = CMP_PSW_NONE;
        nsw_nxt[g*3 +: 3] = CMP_NSW_NONE;
        if (comparator_enable_bit[g]) begin
          case (positive_channel_select[g*3 +: 3])
            CMP_PCH_PIN: psw_nxt[g*4 +: 4] = CMP_PSW_PIN;
            CMP_PCH_DAC: psw_nxt[g*4 +: 4] = CMP_PSW_DAC;
            CMP_PCH_FVR: psw_nxt[g*4 +: 4] = CMP_PSW_FVR;
            CMP_PCH_GND: psw_nxt[g*4 +: 4] = CMP_PSW_GND;
            default:     psw_nxt[g*4 +: 4] = CMP_PSW_NONE;
          endcase
          case (negative_channel_select[g*3 +: 3])
            CMP_NCH_PIN: nsw_nxt[g*3 +: 3] = CMP_NSW_PIN;
            CMP_NCH_FVR: nsw_nxt[g*3 +: 3] = CMP_NSW_FVR;
            CMP_NCH_GND: nsw_nxt[g*3 +: 3] = CMP_NSW_GND;
            default:     nsw_nxt[g*3 +: 3] = CMP_NSW_NONE;
          endcase
        end
      end
    end
  endgenerate

  // mirror, pin tap, shutdown and wake
  always_comb begin
    pin_nxt           = comparator_enable_bit & (raw_sync ^ output_invert_bit); // pin tap skips the latch
    mir_nxt           = CMP_MIRROR_RST;
    mir_nxt[NUM-1:0]  = res;
    shut_nxt          = |(res & shutdown_source_enable);
    wake_nxt          = |(flg & comparator_irq_enable);
  end

  // output registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      res_r  <= '0;
      flg_r  <= '0;
      gate_r <= '0;
      pin_r  <= '0;
      hys_r  <= '0;
      mir_r  <= CMP_MIRROR_RST;
      shut_r <= 1'b0;
      wake_r <= 1'b0;
      psw_r  <= '0;
      nsw_r  <= '0;
    end else begin
      res_r  <= res;
      flg_r  <= flg;
      gate_r <= res;
      pin_r  <= pin_nxt;
      hys_r  <= hysteresis_enable_bit & comparator_enable_bit;
      mir_r  <= mir_nxt;
      shut_r <= shut_nxt;
      wake_r <= wake_nxt;
      psw_r  <= psw_nxt;
      nsw_r  <= nsw_nxt;
    end
  end

  assign comparator_result_bit         = res_r;
  assign shared_output_mirror_register = mir_r;
  assign comparator_irq_flag           = flg_r;
  assign timer1_gate_source            = gate_r;
  assign pin_route_out                 = pin_r;
  assign waveform_shutdown             = shut_r;
  assign wake_request                  = wake_r;
  assign hysteresis_on                 = hys_r;
  assign positive_switch               = psw_r;
  assign negative_switch               = nsw_r;
endmodule : cmp_ctrl

//--- testbench/cmp_ctrl_props.sv
// concurrent checks on the comparator control ports
`timescale 1ns/100ps
module cmp_ctrl_props
  import cmp_pkg::*;
#(
  parameter int unsigned NUM = CMP_NUM
) (
  input wire logic             clk_sys,
  input wire logic             reset_n,
  input wire logic [NUM-1:0]   comparator_enable_bit,
  input wire logic [NUM-1:0]   hysteresis_enable_bit,
  input wire logic [NUM-1:0]   comparator_irq_enable,
  input wire logic [NUM-1:0]   irq_flag_clear,
  input wire logic [NUM-1:0]   shutdown_source_enable,
  input wire logic [NUM-1:0]   comparator_result_bit,
  input wire logic [7:0]       shared_output_mirror_register,
  input wire logic [NUM-1:0]   comparator_irq_flag,
  input wire logic [NUM-1:0]   timer1_gate_source,
  input wire logic             waveform_shutdown,
  input wire logic             wake_request,
  input wire logic [NUM-1:0]   hysteresis_on,
  input wire logic [NUM*4-1:0] positive_switch,
  input wire logic [NUM*3-1:0] negative_switch
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // result views, flag, wake, shutdown and switches
  a_mirror_upper_zero:
    assert property (shared_output_mirror_register[7:2] == 6'h00) else $error("mirror upper bits set");
  a_mirror_tracks_out:
    assert property ($stable(comparator_result_bit) |->
      shared_output_mirror_register[NUM-1:0] == comparator_result_bit) else $error("mirror differs");
  a_gate_tracks_out:
    assert property ($stable(comparator_result_bit) |-> timer1_gate_source == comparator_result_bit)
      else $error("gate tap differs");
  a_flag_only_cleared:
    assert property ($fell(comparator_irq_flag[0]) |-> $past(irq_flag_clear[0]) || $past(irq_flag_clear[0], 2))
      else $error("flag dropped without clear");
  a_wake_from_flag:
    assert property ((comparator_irq_flag[0] && comparator_irq_enable[0]) [*2] |-> wake_request)
      else $error("no wake with enabled flag");
  a_shutdown_active:
    assert property ((comparator_result_bit[0] && shutdown_source_enable[0]) [*2] |-> waveform_shutdown)
      else $error("no shutdown");
  a_shutdown_masked:
    assert property ((shutdown_source_enable == '0) [*2] |-> !waveform_shutdown) else $error("stray shutdown");
  a_hyst_follows_bits:
    assert property ((reset_n && $stable({hysteresis_enable_bit, comparator_enable_bit})) [*2] |->
      hysteresis_on == (hysteresis_enable_bit & comparator_enable_bit)) else $error("hysteresis wrong");
  a_switch_off_idle:
    assert property ((comparator_enable_bit == '0) [*2] |-> positive_switch == '0 && negative_switch == '0)
      else $error("switch closed while disabled");
  a_switch_one_hot:
    assert property ($onehot0(positive_switch[3:0]) && $onehot0(negative_switch[2:0]))
      else $error("two switches closed");
  a_disabled_out_low:
    assert property ((!comparator_enable_bit[0]) [*8] ##1 (!comparator_enable_bit[0]) [*8] |->
      !comparator_result_bit[0]) else $error("disabled output high");
  // main scenarios reached
  c_flag_set: cover property ($rose(comparator_irq_flag[0]));
  c_wake: cover property ($rose(wake_request));
  c_shutdown: cover property ($rose(waveform_shutdown));
endmodule : cmp_ctrl_props
bind cmp_ctrl cmp_ctrl_props #(.NUM(NUM)) u_props (.clk_sys(clk_sys), .reset_n(reset_n),
  .comparator_enable_bit(comparator_enable_bit), .hysteresis_enable_bit(hysteresis_enable_bit),
  .comparator_irq_enable(comparator_irq_enable), .irq_flag_clear(irq_flag_clear),
  .shutdown_source_enable(shutdown_source_enable), .comparator_result_bit(comparator_result_bit),
  .shared_output_mirror_register(shared_output_mirror_register), .comparator_irq_flag(comparator_irq_flag),
  .timer1_gate_source(timer1_gate_source), .waveform_shutdown(waveform_shutdown),
  .wake_request(wake_request), .hysteresis_on(hysteresis_on), .positive_switch(positive_switch),
  .negative_switch(negative_switch));

//--- testbench/cmp_analog_model.sv
// behavioural analog core of two comparators
`timescale 1ns/100ps
module cmp_analog_model (
  input  wire logic             clk_sys,
  input  wire logic [1:0][11:0] pin_pos_mv,
  input  wire logic [1:0][11:0] pin_neg_mv,
  input  wire logic [11:0]      dac_mv,
  input  wire logic [11:0]      fvr_mv,
  input  wire logic [7:0]       positive_switch,
  input  wire logic [5:0]       negative_switch,
  input  wire logic [1:0]       hysteresis_on,
  output logic      [1:0]       raw_result
);
  int vp, vn, h;
  initial raw_result = 2'h0;
  // steer inputs, compare with optional separation
  always @(posedge clk_sys) begin
    for (int g = 0; g < 2; g++) begin
      vp = positive_switch[g*4] ? pin_pos_mv[g] : positive_switch[g*4+1] ? dac_mv :
           positive_switch[g*4+2] ? fvr_mv : 0; // inputs
      vn = negative_switch[g*3] ? pin_neg_mv[g] : negative_switch[g*3+1] ? fvr_mv : 0; // inputs
      h = hysteresis_on[g] ? 20 : 0; // separation
      if (positive_switch[g*4+:4] == 4'h0 || negative_switch[g*3+:3] == 3'h0)
        raw_result[g] <= ~raw_result[g]; // open inputs wander
      else if (vp > vn + h)
        raw_result[g] <= 1'b1; // compare
      else if (vp < vn - h)
        raw_result[g] <= 1'b0; // compare
    end
  end
endmodule : cmp_analog_model

//--- testbench/tb_comparator_digital_control.sv
// self-checking bench for the comparator control block
`timescale 1ns/100ps
module tb_comparator_digital_control;
  import cmp_pkg::*;
  typedef struct packed {
    logic en; logic inv; logic [1:0] rf; logic [2:0] pch; logic [2:0] nch;
    logic [11:0] vp; logic [11:0] vn; logic exp;
  } cmp_row_s;
  logic             clk_sys, reset_n, t1, slp, wsd, wake;
  logic [1:0]       raw, en, inv, hys, syn, rie, fie, ie, clr, sse, res, flag, gate, pout, hon;
  logic [5:0]       pch, nch, nsw;
  logic [7:0]       mir, psw;
  logic [1:0][11:0] vp, vn;
  cmp_t1src_e       sel;
  int               fails, checked, cyc;
  cmp_row_s rows[9] = '{'{1, 0, 0, CMP_PCH_PIN, CMP_NCH_PIN, 12'h300, 12'h200, 1},
    '{1, 0, 0, CMP_PCH_PIN, CMP_NCH_PIN, 12'h100, 12'h200, 0}, '{1, 1, 0, CMP_PCH_PIN, CMP_NCH_PIN, 12'h300, 12'h200, 0},
    '{1, 0, 0, CMP_PCH_DAC, CMP_NCH_PIN, 12'h000, 12'h200, 1}, '{1, 0, 0, CMP_PCH_FVR, CMP_NCH_PIN, 12'h000, 12'h600, 0},
    '{1, 1, 0, CMP_PCH_GND, CMP_NCH_PIN, 12'h000, 12'h100, 1}, '{1, 0, 0, CMP_PCH_PIN, CMP_NCH_FVR, 12'h500, 12'h000, 1},
    '{1, 1, 0, CMP_PCH_PIN, CMP_NCH_GND, 12'h100, 12'h000, 0}, '{0, 1, 0, CMP_PCH_PIN, CMP_NCH_PIN, 12'h300, 12'h200, 0}};
  cmp_row_s erows[7] = '{'{1, 0, 2, 0, 0, 12'h300, 12'h200, 1}, '{1, 0, 2, 0, 0, 12'h100, 12'h200, 0},
    '{1, 0, 1, 0, 0, 12'h300, 12'h200, 0}, '{1, 0, 1, 0, 0, 12'h100, 12'h200, 1},
    '{1, 1, 3, 0, 0, 12'h100, 12'h200, 1}, '{0, 1, 3, 0, 0, 12'h100, 12'h200, 1}, '{1, 1, 3, 0, 0, 12'h100, 12'h200, 1}};
  cmp_ctrl uut (.clk_sys(clk_sys), .reset_n(reset_n), .raw_result(raw), .t1_src_clk(t1), .t1_src_sel(sel),
    .sleep_mode(slp), .comparator_enable_bit(en), .output_invert_bit(inv), .hysteresis_enable_bit(hys),
    .timer_sync_enable_bit(syn), .rising_edge_irq_enable(rie), .falling_edge_irq_enable(fie),
    .positive_channel_select(pch), .negative_channel_select(nch), .comparator_irq_enable(ie),
    .irq_flag_clear(clr), .shutdown_source_enable(sse), .comparator_result_bit(res),
    .shared_output_mirror_register(mir), .comparator_irq_flag(flag), .timer1_gate_source(gate),
    .pin_route_out(pout), .waveform_shutdown(wsd), .wake_request(wake), .hysteresis_on(hon),
    .positive_switch(psw), .negative_switch(nsw));
  cmp_analog_model u_ana (.clk_sys(clk_sys), .pin_pos_mv(vp), .pin_neg_mv(vn), .dac_mv(12'h280),
    .fvr_mv(12'h400), .positive_switch(psw), .negative_switch(nsw), .hysteresis_on(hon), .raw_result(raw));
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apply(cmp_row_s r);
    @(posedge clk_sys);
    {en, inv, rie, fie} <= {{2{r.en}}, {2{r.inv}}, {2{r.rf[1]}}, {2{r.rf[0]}}};
    {pch, nch, vp, vn} <= {{2{r.pch}}, {2{r.nch}}, {2{r.vp}}, {2{r.vn}}};
  endtask : apply
  task automatic t1_pulse;
    @(posedge clk_sys);
    t1 <= 1'b1;
    tick(6);
    t1 <= 1'b0;
    tick(16);
  endtask : t1_pulse
  task report_and_stop;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    {reset_n, t1, slp, en, inv, hys, syn, rie, fie, clr, sse, pch, nch, vp, vn} = '0;
    {fails, checked, cyc} = '0;
    sel = CMP_T1_EXT;
    ie = 2'h3; // interrupt enables set
    tick(10);
    reset_n <= 1'b1;
    tick(2);
    chk("reset outputs", {res, flag, gate, wsd, wake}, 8'h00); // quiet after reset
    foreach (rows[i]) begin
      apply(rows[i]);
      tick(16);
      chk("result taps", {res, gate, pout, mir[1:0]}, {8{rows[i].exp}});
    end
    foreach (erows[i]) begin
      @(posedge clk_sys);
      clr <= 2'h3;
      @(posedge clk_sys);
      clr <= 2'h0;
      tick(4);
      apply(erows[i]);
      tick(16);
      chk("irq flag", flag, {2{erows[i].exp}}); // edges
      chk("wake", wake, erows[i].exp); // wake
    end
    t1_pulse(); // prime the timer-side latch with the present output
    syn <= 2'h3;
    tick(16);
    vp <= {2{12'h300}};
    tick(20);
    chk("held result", res, 2'h3); // no timer edge yet
    t1_pulse();
    chk("synced result", {res, gate}, 4'h0);
    sel <= CMP_T1_SYS;
    slp <= 1'b1;
    vp <= {2{12'h100}};
    t1_pulse();
    chk("sleep hold", res, 2'h0);
    slp <= 1'b0;
    t1_pulse();
    chk("wake update", res, 2'h3);
    sse <= 2'h1;
    tick(6);
    chk("shutdown", wsd, 1'b1);
    sse <= 2'h0;
    hys <= 2'h3;
    tick(6);
    chk("shutdown off", wsd, 1'b0);
    chk("hysteresis", hon, 2'h3);
    // second reset in mid-run, sync off afterwards
    reset_n <= 1'b0;
    syn     <= 2'h0;
    tick(2);
    chk("reset again", {res, flag, gate, wsd, wake}, 8'h00);
    chk("reset taps", {hon, pout, mir[3:0]}, 8'h00);
    reset_n <= 1'b1;
    // first instruction tick latches the inverted low input; clear lands on the edge cycle
    tick(4);
    clr <= 2'h3;
    tick(1);
    clr <= 2'h0;
    tick(4);
    chk("set beats clear", flag, 2'h3);
    // only comparator 1 enabled: mirror bit order
    en <= 2'h1;
    tick(12);
    chk("mirror order", mir, 8'h01);
    chk("result order", {res, pout, gate}, 6'h15);
    report_and_stop();
  end
endmodule : tb_comparator_digital_control
